// ### hdl/otp_status_map.svh
// Register offsets, bit positions and reset values of the OTP status block
`ifndef OTP_STATUS_MAP_SVH
`define OTP_STATUS_MAP_SVH
`define PROG_STAT_IDX 12'h519
`define PAGE1_STAT_IDX 12'h51A
`define PROG_STAT_ADDR 14'h1464
`define PAGE1_STAT_ADDR 14'h1468
`define CTRL_ADDR 14'h1400
`define UNLOCK_ADDR 14'h1404
`define IRQ_STAT_ADDR 14'h1408
`define IRQ_MASK_ADDR 14'h140C
`define CTRL_START_BIT 0
`define CTRL_PAGE_BIT 1
`define UNLOCK_KEY 8'hA5
`define STAT_RESET 8'h00
`define IRQ_DONE_BIT 0
`define IRQ_PERR_BIT 1
`define IRQ_LERR_BIT 2
`define IRQ_LWRN_BIT 3
`define P1_LOADED_BIT 7
`define P1_WARN_BIT 6
`define P1_LERR_BIT 5
`define P1_FMT_BIT 4
`define P1_VALID_BIT 3
`define P1_LOW_VOLTAGE_HEALTH_BIT 2
`define P1_HIGH_VOLTAGE_HEALTH_BIT 1
`define P1_TRY_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### hdl/otp_status_pkg.sv
// Types shared by the OTP status block
package otp_status_pkg;
  typedef enum logic [0:0] {
    PROG_IDLE = 1'b0,
    PROG_BUSY = 1'b1
  } prog_state_t;
  typedef logic [7:0] stat_byte_t;
endpackage

// ### hdl/otp_program_status.sv
// OTP programming and page 1 status registers with AXI4-Lite slave
// How it works
// - After a successful unlock the next write must hit the control register; any other write except another key write relocks.
// - The load warning flag is set when page 1 loaded with one or more single-bit corrections.
// - The load error flag is set when a double-bit error is seen while loading page 1.
// - The format error flag is high when a voltage health bit is set but no first attempt was made.
// - Page 1 reads valid only after its programming finished without fault.
// - The low voltage health bit reads zero on a supply undervoltage, an overvoltage, or no attempt.
// - The high voltage health bit reads zero on a supply overvoltage or when nothing was attempted.
// - The first attempt bit is set once a programming attempt of page 1 has been made.
// - The load error flag reads zero both when no error occurred and when no load was attempted.
`timescale 1ns/1ns
`include "otp_status_map.svh"
module otp_program_status
  import otp_status_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Programming engine
  output logic prog_start,
  output logic prog_page,
  input wire logic prog_finish,
  input wire logic fault_overtemp,
  input wire logic fault_supply_low,
  input wire logic fault_supply_high,
  input wire logic fault_stress_low,
  input wire logic fault_stress_high,
  // Page 1 load results
  input wire logic load_finish,
  input wire logic load_page1_selected,
  input wire logic single_bit_correction,
  input wire logic double_bit_detection,
  input wire logic stored_page_valid,
  input wire logic stored_low_voltage_health,
  input wire logic stored_high_voltage_health,
  input wire logic stored_first_attempt,
  // Interrupt
  output logic irq
);

////////////////////////////////////////////////////////////////////////////////
// Write channel capture

  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Write decode

  wire [13:0] wa = 14'(awaddr_r);
  wire lane0 = wstrb_r[0];
  wire wr_ctrl = wr_fire && (wa == `CTRL_ADDR);
  wire wr_unlock = wr_fire && (wa == `UNLOCK_ADDR);
  wire wr_istat = wr_fire && (wa == `IRQ_STAT_ADDR);
  wire wr_imask = wr_fire && (wa == `IRQ_MASK_ADDR);
  wire wr_ro = wr_fire && ((wa == `PROG_STAT_ADDR) || (wa == `PAGE1_STAT_ADDR));
  wire wr_mapped = wr_ctrl || wr_unlock || wr_istat || wr_imask || wr_ro;
  wire start_req = wr_ctrl && lane0 && wdata_r[`CTRL_START_BIT];
  wire start_page = wdata_r[`CTRL_PAGE_BIT];
  wire key_ok = wr_unlock && lane0 && (wdata_r[7:0] == `UNLOCK_KEY);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Unlock and programming sequencer

  logic unlocked_r;
  logic unlocked_nxt;
  prog_state_t state_r;
  prog_state_t state_nxt;
  logic page_r;
  logic start_r;
  stat_byte_t page1_r;
  wire fmt_err;

  // Start is refused when locked, or on page 1 already tried or malformed
  wire start_bad = !unlocked_r || (!start_page && (page1_r[`P1_TRY_BIT] || fmt_err));
  wire start_go = start_req && !start_bad && (state_r == PROG_IDLE);

  always_comb begin
    unlocked_nxt = unlocked_r;
    if (start_req) begin
      unlocked_nxt = 1'b0;
    end else if (key_ok) begin
      unlocked_nxt = 1'b1;
    end else if (wr_fire && !wr_ctrl) begin
      unlocked_nxt = 1'b0;
    end
  end

  always_comb begin
    case (state_r)
      PROG_IDLE: begin
        state_nxt = start_go ? PROG_BUSY : PROG_IDLE;
      end
      PROG_BUSY: begin
        state_nxt = prog_finish ? PROG_IDLE : PROG_BUSY;
      end
      default: begin
        state_nxt = PROG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      unlocked_r <= 1'b0;
      state_r <= PROG_IDLE;
      page_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      unlocked_r <= unlocked_nxt;
      state_r <= state_nxt;
      start_r <= start_go;
      if (start_go) begin
        page_r <= start_page;
      end
    end
  end

  assign prog_start = start_r;
  assign prog_page = page_r;

////////////////////////////////////////////////////////////////////////////////
// Programming status byte

  logic [6:0] outcome_r;
  wire prog_end = (state_r == PROG_BUSY) && prog_finish;
  wire any_fault = fault_overtemp || fault_supply_low || fault_supply_high ||
                   fault_stress_low || fault_stress_high;
  wire [6:0] fault_bits = {fault_overtemp, fault_supply_low, fault_supply_high,
                           fault_stress_low, fault_stress_high, 1'b0, !any_fault};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outcome_r <= 7'h00;
    end else if (start_req) begin
      outcome_r <= {6'h00, 1'b0} | {5'h00, start_bad, 1'b0};
    end else if (prog_end) begin
      outcome_r <= fault_bits;
    end
  end

  wire [7:0] prog_stat = {unlocked_r, outcome_r};

////////////////////////////////////////////////////////////////////////////////
// Page 1 status byte

  // Bit order: loaded, warn, error, fmt, valid, uv ok, ov ok, try
  wire p1_prog_end = prog_end && !page_r;
  wire uv_seen = fault_supply_low || fault_supply_high;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page1_r <= `STAT_RESET;
    end else if (load_finish) begin
      page1_r[`P1_LOADED_BIT] <= load_page1_selected;
      page1_r[`P1_WARN_BIT] <= load_page1_selected && single_bit_correction;
      page1_r[`P1_LERR_BIT] <= load_page1_selected && double_bit_detection;
      page1_r[`P1_VALID_BIT] <= stored_page_valid;
      page1_r[`P1_LOW_VOLTAGE_HEALTH_BIT] <= stored_low_voltage_health;
      page1_r[`P1_HIGH_VOLTAGE_HEALTH_BIT] <= stored_high_voltage_health;
      page1_r[`P1_TRY_BIT] <= stored_first_attempt;
    end else if (start_go && !start_page) begin
      page1_r[`P1_TRY_BIT] <= 1'b1;
    end else if (p1_prog_end) begin
      page1_r[`P1_VALID_BIT] <= !any_fault;
      page1_r[`P1_LOW_VOLTAGE_HEALTH_BIT] <= !uv_seen;
      page1_r[`P1_HIGH_VOLTAGE_HEALTH_BIT] <= !fault_supply_high;
    end
  end

  wire health_any = page1_r[`P1_LOW_VOLTAGE_HEALTH_BIT] || page1_r[`P1_HIGH_VOLTAGE_HEALTH_BIT];
  assign fmt_err = health_any && !page1_r[`P1_TRY_BIT];
  wire [7:0] fmt_mask = 8'h01 << `P1_FMT_BIT;
  wire [7:0] page1_stat = fmt_err ? (page1_r | fmt_mask) : (page1_r & ~fmt_mask);

////////////////////////////////////////////////////////////////////////////////
// Interrupt status and mask

  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  wire [3:0] irq_evt;
  assign irq_evt[`IRQ_DONE_BIT] = prog_end && !any_fault;
  assign irq_evt[`IRQ_PERR_BIT] = start_req && start_bad;
  assign irq_evt[`IRQ_LERR_BIT] = load_finish && load_page1_selected && double_bit_detection;
  assign irq_evt[`IRQ_LWRN_BIT] = load_finish && load_page1_selected && single_bit_correction;
  wire [3:0] irq_clr = (wr_istat && lane0) ? wdata_r[3:0] : 4'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      if (wr_imask && lane0) begin
        irq_mask_r <= wdata_r[3:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

////////////////////////////////////////////////////////////////////////////////
// Read channel

  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [13:0] ra = 14'(s_axi_araddr);
  wire rd_ps = (ra == `PROG_STAT_ADDR);
  wire rd_p1 = (ra == `PAGE1_STAT_ADDR);
  wire rd_ctrl = (ra == `CTRL_ADDR);
  wire rd_unlock = (ra == `UNLOCK_ADDR);
  wire rd_is = (ra == `IRQ_STAT_ADDR);
  wire rd_im = (ra == `IRQ_MASK_ADDR);
  wire rd_hit = rd_ps || rd_p1 || rd_ctrl || rd_unlock || rd_is || rd_im;
  wire [31:0] ctrl_view = {30'h0, page_r, 1'b0};
  wire [31:0] rd_mux = rd_ps ? {24'h0, prog_stat} :
                       rd_p1 ? {24'h0, page1_stat} :
                       rd_ctrl ? ctrl_view :
                       rd_is ? {28'h0, irq_stat_r} :
                       rd_im ? {28'h0, irq_mask_r} : 32'h0;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// ### verification/otp_program_status_props.sv
// Bus and status checks for the OTP status block
`timescale 1ns/1ns
`include "otp_status_map.svh"
module otp_status_checker #(parameter int ADDR_W = 14) (
  input wire logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready, prog_start, irq,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [ADDR_W-1:0] s_axi_araddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire mapped = s_axi_araddr inside {`CTRL_ADDR, `UNLOCK_ADDR, `IRQ_STAT_ADDR, `IRQ_MASK_ADDR,
    `PROG_STAT_ADDR, `PAGE1_STAT_ADDR};
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_done;
    s_axi_rvalid && s_axi_rready;
  endsequence
  chk_read_answer: assert property (ar_go |=> s_axi_rvalid) else $error("read not answered");
  chk_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid) else $error("write not answered");
  chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  chk_r_release: assert property (rd_done |=> !s_axi_rvalid) else $error("rvalid stuck");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_unmapped_err: assert property (ar_go && !mapped |=> s_axi_rresp == `RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_mapped_ok: assert property (ar_go && mapped |=> s_axi_rresp == `RESP_OKAY)
    else $error("mapped read refused");
  chk_start_pulse: assert property (prog_start |=> !prog_start) else $error("start pulse long");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !s_axi_rvalid && !s_axi_bvalid && !prog_start && !irq) else $error("reset not quiet");
endmodule
bind otp_program_status otp_status_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .prog_start(prog_start), .irq(irq), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .s_axi_araddr(s_axi_araddr));

// ### verification/tb_otp_program_status.sv
// Self-checking bench for the OTP status block
`timescale 1ns/1ns
`include "otp_status_map.svh"
module tb_otp_program_status
  import otp_status_pkg::*;
;
  logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic fin = 0, lfin = 0, lsel = 0, sbc = 0, dbd = 0;
  logic [13:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [4:0] flt = '0, f;
  logic [3:0] st = '0;
  stat_byte_t e;
  wire awready, wready, bvalid, arready, rvalid, pstart, ppage, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int miscompares = 0, num_checks = 0, starts = 0;
  always #20 clk = ~clk;
  otp_program_status DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .prog_start(pstart), .prog_page(ppage), .prog_finish(fin),
    .fault_overtemp(flt[4]), .fault_supply_low(flt[3]), .fault_supply_high(flt[2]),
    .fault_stress_low(flt[1]), .fault_stress_high(flt[0]), .load_finish(lfin),
    .load_page1_selected(lsel), .single_bit_correction(sbc), .double_bit_detection(dbd),
    .stored_page_valid(st[3]), .stored_low_voltage_health(st[2]),
    .stored_high_voltage_health(st[1]), .stored_first_attempt(st[0]), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic axw(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    bready <= 0;
  endtask
  task automatic axr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tr;
    rq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      @(posedge clk);
      if (ta) arvalid <= 0;
    end while (!tr);
    rready <= 0;
  endtask
  task automatic rst;
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
  endtask
  // Start request, then engine finish with the given faults
  task automatic prog(input logic pg, input logic [4:0] fv);
    axw(`CTRL_ADDR, {30'h0, pg, 1'b1}, `RESP_OKAY);
    @(posedge clk);
    flt <= fv;
    fin <= 1;
    @(posedge clk);
    fin <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst_n && rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (rst_n && bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rst_n && pstart) starts++;
  end
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  initial begin
    void'($urandom(33770));
    rst();
    axr(`PROG_STAT_ADDR, 32'h0, `RESP_OKAY);
    axr(`PAGE1_STAT_ADDR, 32'h0, `RESP_OKAY);
    axr(14'h1470, 32'h0, `RESP_SLVERR);
    axw(14'h1470, 32'hFF, `RESP_SLVERR);
    axw(`PAGE1_STAT_ADDR, 32'hFF, `RESP_OKAY);
    axw(`CTRL_ADDR, 32'h1, `RESP_OKAY);
    axr(`PROG_STAT_ADDR, 32'h2, `RESP_OKAY);
    axw(`UNLOCK_ADDR, 32'hA5, `RESP_OKAY);
    axr(`PROG_STAT_ADDR, 32'h82, `RESP_OKAY);
    axw(`IRQ_MASK_ADDR, 32'h0, `RESP_OKAY);
    axr(`PROG_STAT_ADDR, 32'h02, `RESP_OKAY);
    axw(`UNLOCK_ADDR, 32'hA5, `RESP_OKAY);
    axw(`CTRL_ADDR, 32'h0, `RESP_OKAY);
    axr(`PROG_STAT_ADDR, 32'h82, `RESP_OKAY);
    prog(1'b1, 5'h03);
    chk(starts, 1);
    chk(ppage, 1'b1);
    axr(`CTRL_ADDR, 32'h2, `RESP_OKAY);
    axr(`PROG_STAT_ADDR, 32'h0C, `RESP_OKAY);
    axr(`PAGE1_STAT_ADDR, 32'h0, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      f = (i == 3) ? 5'($urandom) : ((i == 0) ? 5'h00 : ((i == 1) ? 5'h08 : 5'h04));
      rst();
      axw(`UNLOCK_ADDR, 32'hA5, `RESP_OKAY);
      prog(1'b0, f);
      chk(starts, i + 2);
      chk(ppage, 1'b0);
      axr(`PROG_STAT_ADDR, {24'h0, 1'b0, f, 1'b0, f == 5'h0}, `RESP_OKAY);
      axr(`PAGE1_STAT_ADDR, {28'h0, f == 5'h0, !(f[3] | f[2]), !f[2], 1'b1}, `RESP_OKAY);
    end
    axw(`UNLOCK_ADDR, 32'hA5, `RESP_OKAY);
    axw(`CTRL_ADDR, 32'h1, `RESP_OKAY);
    chk(starts, 5);
    axr(`PROG_STAT_ADDR, 32'h02, `RESP_OKAY);
    chk(irq, 1'b0);
    axw(`IRQ_MASK_ADDR, 32'h2, `RESP_OKAY);
    chk(irq, 1'b1);
    axw(`IRQ_STAT_ADDR, 32'h2, `RESP_OKAY);
    chk(irq, 1'b0);
    axr(`IRQ_STAT_ADDR, {31'h0, f == 5'h0}, `RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      e = 8'($urandom);
      @(posedge clk);
      lsel <= e[7];
      sbc <= e[6];
      dbd <= e[5];
      st <= e[3:0];
      lfin <= 1;
      @(posedge clk);
      lfin <= 0;
      axr(`PAGE1_STAT_ADDR, {24'h0, e[7], e[6] & e[7], e[5] & e[7], (e[2] | e[1]) & !e[0],
        e[3:0]}, `RESP_OKAY);
    end
    // Health set with no attempt: a page 1 start must be refused
    @(posedge clk);
    st <= 4'h4;
    lfin <= 1;
    @(posedge clk);
    lfin <= 0;
    axw(`UNLOCK_ADDR, 32'hA5, `RESP_OKAY);
    axw(`CTRL_ADDR, 32'h1, `RESP_OKAY);
    axr(`PROG_STAT_ADDR, 32'h02, `RESP_OKAY);
    chk(starts, 5);
    test_done();
  end
endmodule
